// ### bench/dcc_ctrl_properties.sv
`timescale 1ns/1ns
module dcc_ctrl_properties
	import dcc_pkg::*;
(
	// clocking
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic clk_en,
	// bus
	input wire logic s_axi_awready,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_rvalid,
	// engine
	input wire dcc_event_s eng_evt,
	input wire dcc_mode_e [31:0] ch_mode,
	input wire dcc_state_s ch_state
);
	logic wp;
	logic [31:0] tg;
	// a taken write commits on the edge that raises bvalid
	assign wp = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
	always_comb begin
		for (int i = 0; i < 32; i++)
			tg[i] = (ch_mode[i] inside {DCC_MODE_PINGPONG, DCC_MODE_SCATTER})
				&& (ch_state.alt_sel[i] ? eng_evt.alt_done[i]
				: eng_evt.pri_done[i]);
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (sys_rst);
	a_alt_toggle: assert property (clk_en && !wp |=>
		ch_state.alt_sel == ($past(ch_state.alt_sel) ^ $past(tg)))
		else $error("alt select wrong");
	a_end_drops: assert property (clk_en && !wp |=>
		!(ch_state.enable & ($past(eng_evt.cycle_end)
		| $past(eng_evt.stop_fetch)))) else $error("enable kept");
	a_berr_drops: assert property (clk_en && !wp &&
		eng_evt.bus_error |=> ch_state.enable == 32'h0)
		else $error("enable kept on error");
	a_enable_no_rise: assert property (clk_en && !wp |=>
		!(ch_state.enable & ~$past(ch_state.enable)))
		else $error("enable rose");
	a_mask_steady: assert property (clk_en && !wp |=>
		$stable(ch_state.req_mask)) else $error("mask moved");
	a_write_answer: assert property (wp && clk_en |=>
		s_axi_bvalid) else $error("no write answer");
	a_read_answer: assert property (s_axi_arvalid &&
		!s_axi_rvalid && clk_en |=> s_axi_rvalid) else $error("no read");
	a_resp_single: assert property (s_axi_bvalid &&
		s_axi_bready && clk_en |=> !s_axi_bvalid) else $error("bvalid");
endmodule
bind dcc_ctrl dcc_ctrl_properties i_dcc_ctrl_properties (.*);

// ### bench/test_dcc_ctrl.sv
`timescale 1ns/1ns
`include "dcc_regs.svh"
`define CK(a, b) begin checked++; if ((a) !== (b)) begin \
	num_errors++; $display("BAD %0t %h %h", $time, a, b); end end
module test_dcc_ctrl
	import dcc_pkg::*;
;
	logic mclk = 1'h0, sys_rst = 1'h1, clk_en = 1'h1;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_arvalid = 1'h0;
	logic s_axi_bready = 1'h1, s_axi_rready = 1'h1;
	logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic s_axi_arready, s_axi_rvalid;
	dcc_event_s eng_evt = '0;
	dcc_mode_e [31:0] ch_mode;
	dcc_state_s ch_state;
	int num_errors = 0, checked = 0;
	always #2 mclk = ~mclk;
	dcc_ctrl i_dcc_ctrl (.*);
	task automatic wr(input logic [11:0] a, input logic [31:0] d,
		input logic [1:0] r);
		logic ta, tw, tb;
		int n;
		n = 0;
		tb = 1'h0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		while (!tb && n < 40) begin
			@(negedge mclk);
			ta = s_axi_awready;
			tw = s_axi_wready;
			tb = s_axi_bvalid;
			if (tb) `CK(s_axi_bresp, r)
			@(posedge mclk);
			if (ta) s_axi_awvalid <= 1'h0;
			if (tw) s_axi_wvalid <= 1'h0;
			n++;
		end
		if (!tb) begin
			num_errors++;
			give_verdict;
		end
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		logic ta, tr;
		int n;
		n = 0;
		tr = 1'h0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		while (!tr && n < 40) begin
			@(negedge mclk);
			ta = s_axi_arready;
			tr = s_axi_rvalid;
			if (tr) `CK({s_axi_rresp, s_axi_rdata}, {`DCC_RESP_OKAY, e})
			@(posedge mclk);
			if (ta) s_axi_arvalid <= 1'h0;
			n++;
		end
		if (!tr) begin
			num_errors++;
			give_verdict;
		end
	endtask
	task automatic pulse(input dcc_event_s e);
		eng_evt <= e;
		@(posedge mclk);
		eng_evt <= '0;
		@(posedge mclk);
	endtask
	task automatic give_verdict;
		$display("errors %0d checks %0d", num_errors, checked);
		if (num_errors == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		logic [11:0] b;
		dcc_event_s e;
		for (int i = 0; i < 32; i++)
			ch_mode[i] = DCC_MODE_PINGPONG;
		// basic and auto channels must never toggle on their own
		ch_mode[0] = DCC_MODE_BASIC;
		ch_mode[1] = DCC_MODE_AUTO;
		ch_mode[2] = DCC_MODE_SCATTER;
		repeat (16) @(posedge mclk);
		sys_rst <= 1'h0;
		@(posedge mclk);
		b = `DCC_OFS_MASK_SET;
		// bit 2 stays clear: channel 2 runs scatter, so no alternate first
		for (int i = 0; i < 3; i++) begin
			rd(b, 32'h0);
			wr(b, 32'ha5a50f0b, `DCC_RESP_OKAY);
			wr(b, 32'h0, `DCC_RESP_OKAY);
			rd(b, 32'ha5a50f0b);
			wr(b + 12'h4, 32'h0000ffff, `DCC_RESP_OKAY);
			rd(b + 12'h4, 32'h0);
			rd(b, 32'ha5a50000);
			b += 12'h8;
		end
		`CK(ch_state.req_mask, 32'ha5a50000)
		wr(12'h100, 32'hffffffff, `DCC_RESP_SLVERR);
		rd(`DCC_OFS_EN_SET, 32'ha5a50000);
		wr(`DCC_OFS_ALT_CLR, 32'hffffffff, `DCC_RESP_OKAY);
		wr(`DCC_OFS_EN_SET, 32'hffffffff, `DCC_RESP_OKAY);
		e = '0;
		e.cycle_end = 32'h8;
		e.stop_fetch = 32'h20;
		pulse(e);
		rd(`DCC_OFS_EN_SET, 32'hffffffd7);
		e = '0;
		e.bus_error = 1'h1;
		// a frozen block must ignore the error pulse
		clk_en <= 1'h0;
		pulse(e);
		clk_en <= 1'h1;
		rd(`DCC_OFS_EN_SET, 32'hffffffd7);
		pulse(e);
		rd(`DCC_OFS_EN_SET, 32'h0);
		e = '0;
		e.cycle_end = 32'h1;
		// the set write commits on the edge that also sees the end pulse
		fork
			wr(`DCC_OFS_EN_SET, 32'h1, `DCC_RESP_OKAY);
			begin
				@(posedge mclk);
				eng_evt <= e;
				@(posedge mclk);
				eng_evt <= '0;
			end
		join
		rd(`DCC_OFS_EN_SET, 32'h1);
		e = '0;
		e.pri_done = 32'hffffffff;
		pulse(e);
		rd(`DCC_OFS_ALT_SET, 32'hfffffffc);
		pulse(e);
		rd(`DCC_OFS_ALT_SET, 32'hfffffffc);
		e = '0;
		e.alt_done = 32'hffffffff;
		pulse(e);
		rd(`DCC_OFS_ALT_SET, 32'h0);
		give_verdict;
	end
endmodule

// ### verilog/dcc_ctrl.sv
// Register access over AXI4-Lite and the address map are this design's own decisions.
`timescale 1ns/1ns
`include "dcc_regs.svh"

module dcc_ctrl
	import dcc_pkg::*;
#(
	parameter int NUM_CH = 32
) (
	// clock, reset, enable
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic clk_en,
	// axi4-lite write address
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// axi4-lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read address
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// axi4-lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// channel engine side
	input wire dcc_event_s eng_evt,
	input wire dcc_mode_e [31:0] ch_mode,
	output dcc_state_s ch_state
);

	// the mask, enable and select words hold one bit per channel
	generate
		if (NUM_CH < 1 || NUM_CH > 32) begin : g_bad_num_ch
			$error("NUM_CH must lie in 1..32");
		end
	endgenerate

	logic [31:0] mask_reg;
	logic [31:0] en_reg;
	logic [31:0] alt_reg;
	logic [11:0] aw_reg;
	logic aw_hold_reg;
	logic [31:0] w_reg;
	logic [3:0] ws_reg;
	logic w_hold_reg;
	logic [31:0] chmask;
	logic [31:0] rst_mask;
	logic [31:0] rst_en;
	logic [31:0] rst_alt;

	assign chmask = (NUM_CH == 32) ? 32'hffffffff :
		((32'h00000001 << NUM_CH) - 32'h00000001);

	// reset images, so each channel takes its own bit of the word
	assign rst_mask = `DCC_RST_MASK;
	assign rst_en = `DCC_RST_EN;
	assign rst_alt = `DCC_RST_ALT;

	// word-wide registers: a partial write would corrupt several channels,
	// so byte strobes select lanes per byte
	function automatic logic [31:0] lane_bits(input logic [3:0] strb,
		input logic [31:0] data);
		logic [31:0] m;
		m = '0;
		for (int i = 0; i < 4; i++)
			m[i*8 +: 8] = {8{strb[i]}};
		return data & m;
	endfunction

	function automatic logic mapped(input logic [11:0] a);
		case (a)
		`DCC_OFS_MASK_SET, `DCC_OFS_MASK_CLR, `DCC_OFS_EN_SET,
		`DCC_OFS_EN_CLR, `DCC_OFS_ALT_SET, `DCC_OFS_ALT_CLR:
			return 1'b1;
		default:
			return 1'b0;
		endcase
	endfunction

	// only the modes that chain primary and alternate data flip the bit
	function automatic logic chains(input dcc_mode_e mode);
		case (mode)
		DCC_MODE_PINGPONG, DCC_MODE_SCATTER:
			return 1'b1;
		default:
			return 1'b0;
		endcase
	endfunction

	// clear registers are write-only and read back as zero
	function automatic logic [31:0] read_word(input logic [11:0] a);
		case (a)
		`DCC_OFS_MASK_SET: return mask_reg;
		`DCC_OFS_EN_SET: return en_reg;
		`DCC_OFS_ALT_SET: return alt_reg;
		default: return 32'h00000000;
		endcase
	endfunction

	// write channel capture: address and data in either order
	logic wr_fire;
	assign s_axi_awready = !aw_hold_reg && !s_axi_bvalid;
	assign s_axi_wready = !w_hold_reg && !s_axi_bvalid;
	assign wr_fire = aw_hold_reg && w_hold_reg && !s_axi_bvalid;

	// a hold flag closes the ready of its half until the write commits
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			aw_hold_reg <= 1'b0;
		end else if (clk_en) begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_hold_reg <= 1'b1;
			end else if (wr_fire) begin
				aw_hold_reg <= 1'b0;
			end
		end
	end

	// the address is kept until the response, for decode and for bresp
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			aw_reg <= 12'h000;
		end else if (clk_en) begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_reg <= s_axi_awaddr;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			w_hold_reg <= 1'b0;
		end else if (clk_en) begin
			if (s_axi_wvalid && s_axi_wready) begin
				w_hold_reg <= 1'b1;
			end else if (wr_fire) begin
				w_hold_reg <= 1'b0;
			end
		end
	end

	// strobes are kept with the data; strobed-off lanes act as zero
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			w_reg <= 32'h00000000;
			ws_reg <= 4'h0;
		end else if (clk_en) begin
			if (s_axi_wvalid && s_axi_wready) begin
				w_reg <= s_axi_wdata;
				ws_reg <= s_axi_wstrb;
			end
		end
	end

	// bvalid stands until bready; no new write is taken meanwhile
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			s_axi_bvalid <= 1'b0;
		end else if (clk_en) begin
			if (wr_fire) begin
				s_axi_bvalid <= 1'b1;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// unmapped writes are answered but change nothing
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			s_axi_bresp <= `DCC_RESP_OKAY;
		end else if (clk_en) begin
			if (wr_fire) begin
				s_axi_bresp <= mapped(aw_reg) ? `DCC_RESP_OKAY :
					`DCC_RESP_SLVERR;
			end
		end
	end

	// decoded software strobes, one bit per channel
	logic [31:0] wbits;
	logic [31:0] sw_mask_set;
	logic [31:0] sw_mask_clr;
	logic [31:0] sw_en_set;
	logic [31:0] sw_en_clr;
	logic [31:0] sw_alt_set;
	logic [31:0] sw_alt_clr;

	always_comb begin
		wbits = lane_bits(ws_reg, w_reg) & chmask;
		sw_mask_set = '0;
		sw_mask_clr = '0;
		sw_en_set = '0;
		sw_en_clr = '0;
		sw_alt_set = '0;
		sw_alt_clr = '0;
		if (wr_fire) begin
			case (aw_reg)
			`DCC_OFS_MASK_SET: sw_mask_set = wbits;
			`DCC_OFS_MASK_CLR: sw_mask_clr = wbits;
			`DCC_OFS_EN_SET: sw_en_set = wbits;
			`DCC_OFS_EN_CLR: sw_en_clr = wbits;
			`DCC_OFS_ALT_SET: sw_alt_set = wbits;
			`DCC_OFS_ALT_CLR: sw_alt_clr = wbits;
			default: ;
			endcase
		end
	end

	// hardware-driven changes
	logic [31:0] hw_en_clr;
	logic [31:0] hw_toggle;
	logic [31:0] flip_mode;
	logic [31:0] pri_flip;
	logic [31:0] alt_flip;
	logic [31:0] err_all;

	always_comb begin
		for (int c = 0; c < 32; c++)
			flip_mode[c] = chains(ch_mode[c]);
	end

	// a bus error stops every channel, since the failing one is not known here
	assign err_all = {32{eng_evt.bus_error}};
	assign hw_en_clr = (eng_evt.cycle_end | eng_evt.stop_fetch | err_all) &
		chmask;
	// a done pulse flips the bit only when it matches the data in use
	assign pri_flip = eng_evt.pri_done & ~alt_reg;
	assign alt_flip = eng_evt.alt_done & alt_reg;
	assign hw_toggle = flip_mode & chmask & (pri_flip | alt_flip);

	// one set of state per channel; bits above NUM_CH keep their reset value
	generate
		for (genvar c = 0; c < 32; c++) begin : g_ch
			logic sw_m;
			logic sw_e;
			logic sw_a;
			assign sw_m = sw_mask_set[c] | sw_mask_clr[c];
			assign sw_e = sw_en_set[c] | sw_en_clr[c];
			assign sw_a = sw_alt_set[c] | sw_alt_clr[c];

			// request mask: no hardware source, software only
			always_ff @(posedge mclk) begin
				if (sys_rst) begin
					mask_reg[c] <= rst_mask[c];
				end else if (clk_en) begin
					if (sw_m) begin
						mask_reg[c] <= sw_mask_set[c];
					end
				end
			end

			// software to either half overrides an automatic clear
			always_ff @(posedge mclk) begin
				if (sys_rst) begin
					en_reg[c] <= rst_en[c];
				end else if (clk_en) begin
					if (sw_e) begin
						en_reg[c] <= sw_en_set[c];
					end else if (hw_en_clr[c]) begin
						en_reg[c] <= 1'b0;
					end
				end
			end

			// a software selection overrides an automatic flip in that cycle
			always_ff @(posedge mclk) begin
				if (sys_rst) begin
					alt_reg[c] <= rst_alt[c];
				end else if (clk_en) begin
					if (sw_a) begin
						alt_reg[c] <= sw_alt_set[c];
					end else if (hw_toggle[c]) begin
						alt_reg[c] <= ~alt_reg[c];
					end
				end
			end
		end
	endgenerate

	// read channel: one cycle from address to data
	assign s_axi_arready = !s_axi_rvalid;

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			s_axi_rvalid <= 1'b0;
		end else if (clk_en) begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// data and response load only when an address is taken, so they
	// stand unchanged for as long as rvalid waits for rready
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `DCC_RESP_OKAY;
		end else if (clk_en) begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rdata <= read_word(s_axi_araddr);
				s_axi_rresp <= mapped(s_axi_araddr) ? `DCC_RESP_OKAY :
					`DCC_RESP_SLVERR;
			end
		end
	end

	// software must only choose alternate-first in basic, auto or ping-pong
	// modes; the block stores the choice in any mode
	assign ch_state.req_mask = mask_reg;
	assign ch_state.enable = en_reg;
	assign ch_state.alt_sel = alt_reg;

endmodule

// ### verilog/dcc_pkg.sv
package dcc_pkg;
	typedef enum logic [1:0] {
		DCC_MODE_BASIC,
		DCC_MODE_AUTO,
		DCC_MODE_PINGPONG,
		DCC_MODE_SCATTER
	} dcc_mode_e;

	// one event report from the channel engine: per-channel bits plus one shared bus_error
	typedef struct packed {
		logic [31:0] cycle_end;
		logic [31:0] stop_fetch;
		logic [31:0] pri_done;
		logic [31:0] alt_done;
		logic bus_error;
	} dcc_event_s;

	typedef struct packed {
		logic [31:0] req_mask;
		logic [31:0] enable;
		logic [31:0] alt_sel;
	} dcc_state_s;
endpackage

// ### verilog/dcc_regs.svh
`ifndef DCC_REGS_SVH
`define DCC_REGS_SVH

`define DCC_OFS_MASK_SET 12'h020
`define DCC_OFS_MASK_CLR 12'h024
`define DCC_OFS_EN_SET 12'h028
`define DCC_OFS_EN_CLR 12'h02c
`define DCC_OFS_ALT_SET 12'h030
`define DCC_OFS_ALT_CLR 12'h034
`define DCC_RST_MASK 32'h00000000
`define DCC_RST_EN 32'h00000000
`define DCC_RST_ALT 32'h00000000
`define DCC_CYCLE_STOP 3'h0
`define DCC_RESP_OKAY 2'h0
`define DCC_RESP_SLVERR 2'h2

`endif
